// file: verilog/sbit_consts.svh
`ifndef SBIT_CONSTS_SVH
`define SBIT_CONSTS_SVH

// register byte offsets
`define SBIT_OFF_CTRL      8'h00
`define SBIT_OFF_COUNT     8'h04
`define SBIT_OFF_PERIOD    8'h08
`define SBIT_OFF_STATUS    8'h0C
`define SBIT_OFF_IRQ_CLR   8'h10
`define SBIT_OFF_IRQ_EN    8'h14

// timer_control field positions
`define SBIT_CTRL_RUN      15
`define SBIT_CTRL_IDLE     13
`define SBIT_CTRL_GATE     6
`define SBIT_CTRL_PS_HI    5
`define SBIT_CTRL_PS_LO    4
`define SBIT_CTRL_SYNC     2
`define SBIT_CTRL_SRC      1
`define SBIT_CTRL_WMASK    16'hA076

// status, clear and enable field positions
`define SBIT_ST_MATCH      0
`define SBIT_ST_GATE       1
`define SBIT_EN_PRIO_HI    10
`define SBIT_EN_PRIO_LO    8
`define SBIT_EN_WMASK      16'h0703

// reset values
`define SBIT_RST_CTRL      16'h0000
`define SBIT_RST_COUNT     16'h0000
`define SBIT_RST_PERIOD    16'hFFFF
`define SBIT_RST_EN        16'h0000

// prescale terminal counts (ratio minus one)
`define SBIT_PS_TC_1       8'h00
`define SBIT_PS_TC_8       8'h07
`define SBIT_PS_TC_64      8'h3F
`define SBIT_PS_TC_256     8'hFF

// bus responses
`define SBIT_RESP_OKAY     2'h0
`define SBIT_RESP_SLVERR   2'h2

`endif

// file: verilog/sbit_pkg.sv
package sbit_pkg;

    typedef logic [31:0] sbit_data_t;
    typedef logic [7:0]  sbit_addr_t;
    typedef logic [3:0]  sbit_strb_t;
    typedef logic [1:0]  sbit_resp_t;

    typedef enum logic [1:0] {
        SBIT_WR_IDLE = 2'b00,
        SBIT_WR_TAKE = 2'b01,
        SBIT_WR_RESP = 2'b10
    } sbit_wr_state_t;

    typedef enum logic [1:0] {
        SBIT_RD_IDLE = 2'b00,
        SBIT_RD_TAKE = 2'b01,
        SBIT_RD_RESP = 2'b10
    } sbit_rd_state_t;

endpackage : sbit_pkg

// file: verilog/sbit_prescaler.sv
`timescale 1ns/1ps
`include "sbit_consts.svh"

module sbit_prescaler #(
    parameter int PS_W = 8
) (
    // clock and reset
    input  wire logic            i_clk,
    input  wire logic            i_rst,
    input  wire logic            i_ce,
    // control
    input  wire logic            i_clear,
    input  wire logic [1:0]      i_sel,
    // ticks
    input  wire logic            i_tick,
    output logic                 o_tick
);
    import sbit_pkg::*;

    logic [PS_W-1:0] cnt_q;
    logic [PS_W-1:0] cnt_d;
    logic [PS_W-1:0] tc;

    // terminal count of the selected ratio
    function automatic logic [PS_W-1:0] ps_tc(input logic [1:0] sel);
        case (sel)
            2'b11:   ps_tc = PS_W'(`SBIT_PS_TC_256);
            2'b10:   ps_tc = PS_W'(`SBIT_PS_TC_64);
            2'b01:   ps_tc = PS_W'(`SBIT_PS_TC_8);
            default: ps_tc = PS_W'(`SBIT_PS_TC_1);
        endcase
    endfunction : ps_tc

    always_comb begin
        tc     = ps_tc(i_sel);
        o_tick = i_tick && (cnt_q == tc);
        cnt_d  = cnt_q;
        if (i_clear) begin
            cnt_d = '0;
        end else if (i_tick) begin
            cnt_d = (cnt_q == tc) ? '0 : cnt_q + PS_W'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q <= '0;
        end else if (i_ce) begin
            cnt_q <= cnt_d;
        end
    end

endmodule : sbit_prescaler

// file: verilog/sbit_timer.sv
`timescale 1ns/1ps
`include "sbit_consts.svh"

// Function
// - A 16-bit counter works as a timer, a synchronous counter or an asynchronous counter of the count pin.
// - The interrupt is requested on a period match and on a gate fall while gated accumulation is active.
// - Control bit 15 timer_run starts the counter when 1 and stops it when 0.
// - Control bit 13 idle_halt stops the module in idle when set, else it keeps running in idle.
// - Control bit 6 gate_accumulate enables gating with the internal clock and is ignored with the external one.
// - Bits 5-4 prescale_select divide by 256, 64, 8 or 1 for codes 11, 10, 01, 00.
// - Control bit 2 ext_clock_sync synchronises the count pin when external, and is ignored when internal.
// - Control bit 1 clock_source_select picks count pin rising edges when 1 and the internal clock when 0.
// - Control bits 14, 12-7, 3 and 0 read as zero and ignore writes.
// - The timer keeps running in idle unless idle_halt stops it in idle.
module sbit_timer #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_rst,
    input  wire logic               i_ce,
    // device state and pins
    input  wire logic               i_idle,
    input  wire logic               i_ext_count_pin,
    input  wire logic               i_gate,
    // axi4-lite write address and data
    input  wire logic               i_s_axi_awvalid,
    output logic                    o_s_axi_awready,
    input  wire sbit_pkg::sbit_addr_t i_s_axi_awaddr,
    input  wire logic               i_s_axi_wvalid,
    output logic                    o_s_axi_wready,
    input  wire sbit_pkg::sbit_data_t i_s_axi_wdata,
    input  wire sbit_pkg::sbit_strb_t i_s_axi_wstrb,
    // axi4-lite write response
    output logic                    o_s_axi_bvalid,
    input  wire logic               i_s_axi_bready,
    output sbit_pkg::sbit_resp_t    o_s_axi_bresp,
    // axi4-lite read
    input  wire logic               i_s_axi_arvalid,
    output logic                    o_s_axi_arready,
    input  wire sbit_pkg::sbit_addr_t i_s_axi_araddr,
    output logic                    o_s_axi_rvalid,
    input  wire logic               i_s_axi_rready,
    output sbit_pkg::sbit_data_t    o_s_axi_rdata,
    output sbit_pkg::sbit_resp_t    o_s_axi_rresp,
    // interrupt
    output logic                    o_irq,
    output logic [2:0]              o_irq_priority
);
    import sbit_pkg::*;

    // bus state
    sbit_wr_state_t wr_st_q, wr_st_d;
    sbit_rd_state_t rd_st_q, rd_st_d;
    logic           awready_q, awready_d;
    logic           wready_q, wready_d;
    logic           bvalid_q, bvalid_d;
    sbit_resp_t     bresp_q, bresp_d;
    logic           arready_q, arready_d;
    logic           rvalid_q, rvalid_d;
    sbit_data_t     rdata_q, rdata_d;
    sbit_resp_t     rresp_q, rresp_d;

    // registers
    logic [15:0]    ctrl_q, ctrl_d;
    logic [CNT_W-1:0] count_q, count_d;
    logic [CNT_W-1:0] period_q, period_d;
    logic [1:0]     status_q, status_d;
    logic [15:0]    en_q, en_d;
    logic           irq_q, irq_d;

    // pin sampling
    logic           pin_s1_q, pin_s2_q, pin_s3_q;
    logic           pin_a_q, pin_a_prev_q;
    logic           gate_q, gate_prev_q;

    // decoded
    logic           wr_fire;
    logic           ctrl_wr;
    logic [15:0]    wmask;
    logic [15:0]    wval;
    logic           active;
    logic           ext_src;
    logic           gated;
    logic           ext_edge;
    logic           src_tick;
    logic           ps_tick;
    logic           gate_fall;
    logic [1:0]     set_ev;

    // address decode shared by read and write
    function automatic logic addr_ok(input sbit_addr_t a);
        addr_ok = (a == `SBIT_OFF_CTRL) || (a == `SBIT_OFF_COUNT) || (a == `SBIT_OFF_PERIOD) ||
                  (a == `SBIT_OFF_STATUS) || (a == `SBIT_OFF_IRQ_CLR) || (a == `SBIT_OFF_IRQ_EN);
    endfunction : addr_ok

    // timer control decode
    always_comb begin
        active   = ctrl_q[`SBIT_CTRL_RUN] && !(ctrl_q[`SBIT_CTRL_IDLE] && i_idle);
        ext_src  = ctrl_q[`SBIT_CTRL_SRC];
        gated    = ctrl_q[`SBIT_CTRL_GATE] && !ext_src;
        if (ctrl_q[`SBIT_CTRL_SYNC]) begin
            ext_edge = pin_s2_q && !pin_s3_q;
        end else begin
            ext_edge = pin_a_q && !pin_a_prev_q;
        end
        if (ext_src) begin
            src_tick = active && ext_edge;
        end else begin
            src_tick = active && (!gated || gate_q);
        end
        gate_fall = active && gated && gate_prev_q && !gate_q;
    end

    sbit_prescaler #(
        .PS_W (8)
    ) u_prescaler (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_ce    (i_ce),
        .i_clear (!ctrl_q[`SBIT_CTRL_RUN] || ctrl_wr),
        .i_sel   (ctrl_q[`SBIT_CTRL_PS_HI:`SBIT_CTRL_PS_LO]),
        .i_tick  (src_tick),
        .o_tick  (ps_tick)
    );

    // bus handshakes and register file
    always_comb begin
        wr_st_d   = wr_st_q;
        rd_st_d   = rd_st_q;
        awready_d = 1'b0;
        wready_d  = 1'b0;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        arready_d = 1'b0;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        ctrl_d    = ctrl_q;
        count_d   = count_q;
        period_d  = period_q;
        en_d      = en_q;
        wr_fire   = (wr_st_q == SBIT_WR_TAKE);
        wmask     = {{8{i_s_axi_wstrb[1]}}, {8{i_s_axi_wstrb[0]}}};
        wval      = i_s_axi_wdata[15:0];
        ctrl_wr   = wr_fire && (i_s_axi_awaddr == `SBIT_OFF_CTRL);
        set_ev    = 2'b00;

        // timer counting
        if (ps_tick) begin
            if (count_q == period_q) begin
                count_d = '0;
                set_ev[`SBIT_ST_MATCH] = 1'b1;
            end else begin
                count_d = count_q + CNT_W'(1);
            end
        end
        set_ev[`SBIT_ST_GATE] = gate_fall;

        // write channel
        case (wr_st_q)
            SBIT_WR_IDLE: begin
                if (i_s_axi_awvalid && i_s_axi_wvalid) begin
                    wr_st_d   = SBIT_WR_TAKE;
                    awready_d = 1'b1;
                    wready_d  = 1'b1;
                end
            end
            SBIT_WR_TAKE: begin
                wr_st_d  = SBIT_WR_RESP;
                bvalid_d = 1'b1;
                bresp_d  = addr_ok(i_s_axi_awaddr) ? `SBIT_RESP_OKAY : `SBIT_RESP_SLVERR;
                case (i_s_axi_awaddr)
                    `SBIT_OFF_CTRL:   ctrl_d   = (ctrl_q & ~(wmask & `SBIT_CTRL_WMASK)) |
                                                 (wval & wmask & `SBIT_CTRL_WMASK);
                    `SBIT_OFF_COUNT:  count_d  = (count_q & ~wmask) | (wval & wmask);
                    `SBIT_OFF_PERIOD: period_d = (period_q & ~wmask) | (wval & wmask);
                    `SBIT_OFF_IRQ_EN: en_d     = (en_q & ~(wmask & `SBIT_EN_WMASK)) |
                                                 (wval & wmask & `SBIT_EN_WMASK);
                    default:          ctrl_d   = ctrl_q;
                endcase
            end
            SBIT_WR_RESP: begin
                if (i_s_axi_bready) begin
                    wr_st_d  = SBIT_WR_IDLE;
                    bvalid_d = 1'b0;
                end
            end
            default: wr_st_d = SBIT_WR_IDLE;
        endcase

        // sticky status, set wins over clear
        status_d = status_q;
        if (wr_fire && (i_s_axi_awaddr == `SBIT_OFF_IRQ_CLR) && wmask[0]) begin
            status_d = status_q & ~wval[1:0];
        end
        status_d = status_d | set_ev;
        irq_d    = |(status_d & en_d[1:0]);

        // read channel
        case (rd_st_q)
            SBIT_RD_IDLE: begin
                if (i_s_axi_arvalid) begin
                    rd_st_d   = SBIT_RD_TAKE;
                    arready_d = 1'b1;
                end
            end
            SBIT_RD_TAKE: begin
                rd_st_d  = SBIT_RD_RESP;
                rvalid_d = 1'b1;
                rresp_d  = addr_ok(i_s_axi_araddr) ? `SBIT_RESP_OKAY : `SBIT_RESP_SLVERR;
                case (i_s_axi_araddr)
                    `SBIT_OFF_CTRL:   rdata_d = {16'h0000, ctrl_q};
                    `SBIT_OFF_COUNT:  rdata_d = 32'(count_q);
                    `SBIT_OFF_PERIOD: rdata_d = 32'(period_q);
                    `SBIT_OFF_STATUS: rdata_d = {30'h00000000, status_q};
                    `SBIT_OFF_IRQ_EN: rdata_d = {16'h0000, en_q};
                    default:          rdata_d = 32'h00000000;
                endcase
            end
            SBIT_RD_RESP: begin
                if (i_s_axi_rready) begin
                    rd_st_d  = SBIT_RD_IDLE;
                    rvalid_d = 1'b0;
                end
            end
            default: rd_st_d = SBIT_RD_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_st_q   <= SBIT_WR_IDLE;
            rd_st_q   <= SBIT_RD_IDLE;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `SBIT_RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h00000000;
            rresp_q   <= `SBIT_RESP_OKAY;
            ctrl_q    <= `SBIT_RST_CTRL;
            count_q   <= CNT_W'(`SBIT_RST_COUNT);
            period_q  <= CNT_W'(`SBIT_RST_PERIOD);
            status_q  <= 2'b00;
            en_q      <= `SBIT_RST_EN;
            irq_q     <= 1'b0;
        end else if (i_ce) begin
            wr_st_q   <= wr_st_d;
            rd_st_q   <= rd_st_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
            ctrl_q    <= ctrl_d;
            count_q   <= count_d;
            period_q  <= period_d;
            status_q  <= status_d;
            en_q      <= en_d;
            irq_q     <= irq_d;
        end
    end

    // pin samplers: two-stage for sync mode, single stage for async mode
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pin_s1_q     <= 1'b0;
            pin_s2_q     <= 1'b0;
            pin_s3_q     <= 1'b0;
            pin_a_q      <= 1'b0;
            pin_a_prev_q <= 1'b0;
            gate_q       <= 1'b0;
            gate_prev_q  <= 1'b0;
        end else if (i_ce) begin
            pin_s1_q     <= i_ext_count_pin;
            pin_s2_q     <= pin_s1_q;
            pin_s3_q     <= pin_s2_q;
            pin_a_q      <= i_ext_count_pin;
            pin_a_prev_q <= pin_a_q;
            gate_q       <= i_gate;
            gate_prev_q  <= gate_q;
        end
    end

    assign o_s_axi_awready = awready_q;
    assign o_s_axi_wready  = wready_q;
    assign o_s_axi_bvalid  = bvalid_q;
    assign o_s_axi_bresp   = bresp_q;
    assign o_s_axi_arready = arready_q;
    assign o_s_axi_rvalid  = rvalid_q;
    assign o_s_axi_rdata   = rdata_q;
    assign o_s_axi_rresp   = rresp_q;
    assign o_irq           = irq_q;
    assign o_irq_priority  = en_q[`SBIT_EN_PRIO_HI:`SBIT_EN_PRIO_LO];

endmodule : sbit_timer

// file: verif/sbit_timer_checker.sv
`timescale 1ns/1ps
module sbit_timer_checker (
    // clock and reset
    input wire logic                 i_clk,
    input wire logic                 i_rst,
    // bus
    input wire logic                 i_s_axi_awvalid,
    input wire logic                 i_s_axi_wvalid,
    input wire logic                 o_s_axi_awready,
    input wire logic                 o_s_axi_wready,
    input wire logic                 o_s_axi_bvalid,
    input wire logic                 i_s_axi_bready,
    input wire logic                 o_s_axi_arready,
    input wire sbit_pkg::sbit_addr_t i_s_axi_araddr,
    input wire logic                 o_s_axi_rvalid,
    input wire logic                 i_s_axi_rready,
    input wire sbit_pkg::sbit_data_t o_s_axi_rdata,
    input wire sbit_pkg::sbit_resp_t o_s_axi_rresp,
    // interrupt
    input wire logic                 o_irq,
    input wire logic [2:0]           o_irq_priority
);
    import sbit_pkg::*;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_wr_take;
        o_s_axi_awready && o_s_axi_wready;
    endsequence
    sequence s_rd_take;
        o_s_axi_arready;
    endsequence

    a_wr_ready_pair: assert property (o_s_axi_awready == o_s_axi_wready) else $error("write readies split");
    a_wr_taken: assert property (i_s_axi_awvalid && i_s_axi_wvalid && !o_s_axi_bvalid |-> ##[0:2] s_wr_take)
        else $error("write not taken");
    a_wr_resp: assert property (s_wr_take |=> o_s_axi_bvalid) else $error("write response late");
    a_b_drop: assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid) else $error("bvalid stuck");
    a_rd_resp: assert property (s_rd_take |=> o_s_axi_rvalid) else $error("read response late");
    a_r_drop: assert property (o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid) else $error("rvalid stuck");
    a_bad_addr: assert property (s_rd_take and i_s_axi_araddr > 8'h14 |=> o_s_axi_rresp == 2'h2
        && o_s_axi_rdata == 32'h0) else $error("unmapped read not refused");
    a_ctrl_rsvd: assert property (s_rd_take and i_s_axi_araddr == 8'h00 |=>
        (o_s_axi_rdata & 32'hFFFF5F89) == 32'h0) else $error("reserved control bits set");
    a_irq_fall: assert property ($fell(o_irq) |-> $past(o_s_axi_awready)) else $error("irq dropped alone");
    a_prio_write: assert property ($changed(o_irq_priority) |-> $past(o_s_axi_awready))
        else $error("priority changed alone");
endmodule : sbit_timer_checker

// file: verif/sbit_pin_source.sv
`timescale 1ns/1ps
module sbit_pin_source (
    // clock
    input wire logic i_clk,
    // pins
    output logic     o_ext_count_pin,
    output logic     o_gate
);
    initial begin
        o_ext_count_pin = 1'b0;
        o_gate = 1'b0;
    end
    // n rising edges, high hi cycles and low lo cycles each
    task automatic pulses(input int n, input int hi, input int lo);
        for (int k = 0; k < n; k++) begin
            @(posedge i_clk);
            o_ext_count_pin <= 1'b1;
            repeat (hi) @(posedge i_clk);
            o_ext_count_pin <= 1'b0;
            repeat (lo - 1) @(posedge i_clk);
        end
    endtask : pulses
    // gate high for len cycles, then a falling edge
    task automatic gate_open(input int len);
        @(posedge i_clk);
        o_gate <= 1'b1;
        repeat (len) @(posedge i_clk);
        o_gate <= 1'b0;
    endtask : gate_open
endmodule : sbit_pin_source

// file: verif/tb_sbit_timer.sv
`timescale 1ns/1ps
`include "sbit_consts.svh"
module tb_sbit_timer;
    import sbit_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, idle = 1'b0, ce = 1'b1, pin, gate;
    logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    sbit_addr_t  awa = 8'h00, ara = 8'h00;
    sbit_data_t  wd = 32'h0, rdata, got;
    sbit_strb_t  ws = 4'hF;
    sbit_resp_t  bresp, rresp, got_b, got_r;
    logic        awr, wr, bv, arr, rv, irq;
    logic [2:0]  prio;
    logic [15:0] lfsr = 16'hFF6D;
    int          error_cnt = 0, n_compared = 0, cyc = 0;

    always #20 clk = ~clk;

    sbit_pin_source src (.i_clk(clk), .o_ext_count_pin(pin), .o_gate(gate));
    sbit_timer dut (
        .i_clk(clk), .i_rst(rst), .i_ce(ce), .i_idle(idle), .i_ext_count_pin(pin), .i_gate(gate),
        .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_awaddr(awa),
        .i_s_axi_wvalid(wv), .o_s_axi_wready(wr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws),
        .o_s_axi_bvalid(bv), .i_s_axi_bready(bry), .o_s_axi_bresp(bresp),
        .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ara),
        .o_s_axi_rvalid(rv), .i_s_axi_rready(rry), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
        .o_irq(irq), .o_irq_priority(prio)
    );

    function automatic logic [15:0] next_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : next_rand
    // control readback after a lane-strobed write
    function automatic logic [15:0] ctrl_exp(input logic [15:0] old, input logic [15:0] d, input sbit_strb_t s);
        logic [15:0] m;
        m = {{8{s[1]}}, {8{s[0]}}};
        return ((old & ~m) | (d & m)) & `SBIT_CTRL_WMASK;
    endfunction : ctrl_exp

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr_reg(input sbit_addr_t a, input logic [15:0] d, input sbit_strb_t s = 4'hF);
        @(posedge clk);
        awv <= 1'b1;
        wv <= 1'b1;
        awa <= a;
        wd <= {16'h0, d};
        ws <= s;
        bry <= 1'b1;
        do @(posedge clk); while (awr !== 1'b1);
        awv <= 1'b0;
        wv <= 1'b0;
        do @(posedge clk); while (bv !== 1'b1);
        got_b = bresp;
        bry <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input sbit_addr_t a, input logic [31:0] e);
        @(posedge clk);
        arv <= 1'b1;
        ara <= a;
        rry <= 1'b1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        got = rdata;
        got_r = rresp;
        rry <= 1'b0;
        check(got, e);
    endtask : rd_reg
    task automatic finish_test();
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end

    initial begin
        int r;
        logic [15:0] d, sh, p;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // reset values
        rd_reg(`SBIT_OFF_CTRL, 32'h0);
        rd_reg(`SBIT_OFF_COUNT, 32'h0);
        rd_reg(`SBIT_OFF_PERIOD, 32'h0000FFFF);
        rd_reg(`SBIT_OFF_STATUS, 32'h0);
        rd_reg(`SBIT_OFF_IRQ_EN, 32'h0);
        // unmapped address
        wr_reg(8'h18, 16'hFFFF);
        check({30'h0, got_b}, {30'h0, `SBIT_RESP_SLVERR});
        rd_reg(8'h18, 32'h0);
        check({30'h0, got_r}, {30'h0, `SBIT_RESP_SLVERR});
        // random control writes, timer kept stopped
        sh = 16'h0000;
        for (int i = 0; i < 12; i++) begin
            lfsr = next_rand(lfsr);
            d = lfsr & 16'h7FFF;
            wr_reg(`SBIT_OFF_CTRL, d, {2'b00, lfsr[1:0]});
            sh = ctrl_exp(sh, d, {2'b00, lfsr[1:0]});
            rd_reg(`SBIT_OFF_CTRL, {16'h0, sh});
        end
        // external pin through every prescale, both sync modes, gating bit set but ignored
        for (int ps = 0; ps < 4; ps++) begin
            for (int sy = 0; sy < 2; sy++) begin
                r = (ps == 3) ? 256 : (1 << (3 * ps));
                wr_reg(`SBIT_OFF_CTRL, 16'h0000);
                wr_reg(`SBIT_OFF_COUNT, 16'h0000);
                wr_reg(`SBIT_OFF_CTRL, 16'h8042 | 16'(ps << 4) | 16'(sy << 2));
                lfsr = next_rand(lfsr);
                src.pulses(3 * r - 1, 1, 1 + int'(lfsr[0]));
                repeat (4) @(posedge clk);
                rd_reg(`SBIT_OFF_COUNT, 32'h2);
            end
        end
        // stopped timer ignores the pin
        wr_reg(`SBIT_OFF_CTRL, 16'h0002);
        src.pulses(3, 1, 1);
        repeat (4) @(posedge clk);
        rd_reg(`SBIT_OFF_COUNT, 32'h2);
        // idle with and without idle_halt
        @(posedge clk);
        idle <= 1'b1;
        wr_reg(`SBIT_OFF_CTRL, 16'hA002);
        src.pulses(3, 1, 1);
        repeat (4) @(posedge clk);
        rd_reg(`SBIT_OFF_COUNT, 32'h2);
        wr_reg(`SBIT_OFF_CTRL, 16'h8002);
        src.pulses(3, 1, 1);
        repeat (4) @(posedge clk);
        rd_reg(`SBIT_OFF_COUNT, 32'h5);
        idle <= 1'b0;
        // period match at the boundary, then interrupt enable and clear
        lfsr = next_rand(lfsr);
        p = 16'h3 + {13'h0, lfsr[2:0]};
        wr_reg(`SBIT_OFF_PERIOD, p);
        wr_reg(`SBIT_OFF_COUNT, 16'h0000);
        src.pulses(p, 1, 2);
        repeat (4) @(posedge clk);
        rd_reg(`SBIT_OFF_COUNT, {16'h0, p});
        rd_reg(`SBIT_OFF_STATUS, 32'h0);
        src.pulses(1, 1, 1);
        repeat (4) @(posedge clk);
        rd_reg(`SBIT_OFF_COUNT, 32'h0);
        rd_reg(`SBIT_OFF_STATUS, 32'h1);
        check({31'h0, irq}, 32'h0);
        wr_reg(`SBIT_OFF_IRQ_EN, 16'h0503);
        check({31'h0, irq}, 32'h1);
        check({29'h0, prio}, 32'h5);
        rd_reg(`SBIT_OFF_IRQ_EN, 32'h0503);
        wr_reg(`SBIT_OFF_IRQ_CLR, 16'h0001);
        rd_reg(`SBIT_OFF_STATUS, 32'h0);
        check({31'h0, irq}, 32'h0);
        // gated accumulation on the internal clock
        wr_reg(`SBIT_OFF_CTRL, 16'h0000);
        wr_reg(`SBIT_OFF_PERIOD, 16'hFFFF);
        wr_reg(`SBIT_OFF_COUNT, 16'h0000);
        wr_reg(`SBIT_OFF_CTRL, 16'h8040);
        repeat (6) @(posedge clk);
        rd_reg(`SBIT_OFF_COUNT, 32'h0);
        src.gate_open(10);
        repeat (4) @(posedge clk);
        rd_reg(`SBIT_OFF_COUNT, 32'hA);
        rd_reg(`SBIT_OFF_STATUS, 32'h2);
        check({31'h0, irq}, 32'h1);
        wr_reg(`SBIT_OFF_IRQ_CLR, 16'h0003);
        check({31'h0, irq}, 32'h0);
        // free-running internal clock through the 1:8 prescaler, 44 source ticks
        wr_reg(`SBIT_OFF_COUNT, 16'h0000);
        wr_reg(`SBIT_OFF_CTRL, 16'h8010);
        repeat (40) @(posedge clk);
        wr_reg(`SBIT_OFF_CTRL, 16'h0010);
        rd_reg(`SBIT_OFF_COUNT, 32'h5);
        // clock enable low freezes the count pin path
        wr_reg(`SBIT_OFF_CTRL, 16'h8002);
        ce <= 1'b0;
        src.pulses(3, 1, 1);
        repeat (2) @(posedge clk);
        ce <= 1'b1;
        rd_reg(`SBIT_OFF_COUNT, 32'h5);
        src.pulses(2, 1, 1);
        repeat (4) @(posedge clk);
        rd_reg(`SBIT_OFF_COUNT, 32'h7);
        // reset in mid-run
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_reg(`SBIT_OFF_CTRL, 32'h0);
        rd_reg(`SBIT_OFF_IRQ_EN, 32'h0);
        finish_test();
    end
endmodule : tb_sbit_timer

bind sbit_timer sbit_timer_checker u_chk (
    .i_clk, .i_rst, .i_s_axi_awvalid, .i_s_axi_wvalid, .o_s_axi_awready, .o_s_axi_wready,
    .o_s_axi_bvalid, .i_s_axi_bready, .o_s_axi_arready, .i_s_axi_araddr, .o_s_axi_rvalid,
    .i_s_axi_rready, .o_s_axi_rdata, .o_s_axi_rresp, .o_irq, .o_irq_priority
);
